/* rtl/strength_cfg.svh */
// register map, field positions, reset values and timing for the strength block
// Function
// (R01) Mode field 011 enables receive operation
// (R02) IF gain -13.5 to 0 dB, 4.5 dB steps
// (R03) Gain field resets to 0 dB
// (R04) Passive filter field sets single-sided bandwidth
// (R05) Enable bit picks low-pass or polyphase filter
// (R06) Cutoff field sets active filter cutoff
// (R07) Centre field sets polyphase centre frequency
// (R08) Software programs 100 kHz centre for OOK
// (R09) OOK: sample I/Q 16 times per IF2 period
// (R10) FSK: sample I/Q 16 times per deviation period
// (R11) Average over sliding window of 16 samples
// (R12) Strength register refreshed at the sampling rate
// (R13) Strength quantised at 0.5 dB per step
// (R14) Software keeps deviation setting consistent
// (R15) Strength above threshold sets interrupt status
// (R16) Status stays set until written with one
// (R17) Two routing bits steer interrupt to pins
// (R18) Software sets deviation 00000011 for OOK
// (R19) Compare each update; below-threshold never clears status
`ifndef STRENGTH_CFG_SVH
`define STRENGTH_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_FILTER 8'h04
`define OFS_DEVIATION 8'h08
`define OFS_THRESHOLD 8'h0C
`define OFS_STRENGTH 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_IRQ_ROUTE 8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MODE_LSB 0
`define GAIN_LSB 4
`define CPLX_EN_BIT 6
`define PASSIVE_LSB 0
`define CUTOFF_LSB 4
`define CENTRE_LSB 8
`define STRENGTH_IRQ_BIT 0
`define ROUTE_PIN0_BIT 0
`define ROUTE_PIN1_BIT 1

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define MODE_RECEIVE 3'h3
`define MODE_RESET 3'h1
`define GAIN_RESET 2'h0
`define GAIN_STEP_HALF_DB 8'h09
`define DEVIATION_RESET 8'h03
`define THRESHOLD_RESET 8'h00
`define FILTER_RESET 12'h000

// ----------------------------------------------------------------
// timing: deviation unit and sampling rate
// ----------------------------------------------------------------
`define CLK_HZ 125000000
`define DEV_UNIT_HZ 25000
`define SAMPLES_PER_PERIOD 16
`define WINDOW_LEN 16
`define WINDOW_SHIFT 4

`endif

/* rtl/strength_pkg.sv */
// types shared by the strength block modules
package strength_pkg;
  typedef logic [7:0] level_type;          // half-dB level
  typedef logic [31:0] word_type;          // bus data word
  typedef logic [7:0] addr_type;           // bus byte address
  typedef enum {WR_IDLE, WR_RESP} wr_state_type;
  typedef enum {RD_IDLE, RD_DATA} rd_state_type;
  typedef enum {SEL_CONTROL, SEL_FILTER, SEL_DEVIATION, SEL_THRESHOLD,
                SEL_STRENGTH, SEL_IRQ_STATUS, SEL_IRQ_MASK, SEL_IRQ_ROUTE,
                SEL_NONE} reg_sel_type;
endpackage

/* rtl/strength_if.sv */
// link between the sampler and the sliding-window averager
`timescale 1ns/1ps
interface strength_if;
  logic flush;                         // empty the window
  logic sample_valid;                  // one new sample
  strength_pkg::level_type sample;     // combined I/Q level
  logic avg_valid;                     // one new average
  strength_pkg::level_type avg;        // window mean
  modport sampler (output flush, output sample_valid, output sample,
                   input avg_valid, input avg);
  modport averager (input flush, input sample_valid, input sample,
                    output avg_valid, output avg);
endinterface

/* rtl/strength_avg.sv */
// sliding-window mean of the last sixteen strength samples
`timescale 1ns/1ps
`include "strength_cfg.svh"
module strength_avg (
  input wire logic aclk,
  input wire logic aresetn,
  strength_if.averager link
);
  import strength_pkg::*;

  level_type window [`WINDOW_LEN];     // most recent samples
  logic [3:0] ptr;                     // oldest entry
  logic [11:0] sum;                    // running window total
  logic [11:0] next_sum;

  // ----------------------------------------------------------------
  // running total: drop the oldest, add the newest
  // ----------------------------------------------------------------
  always_comb begin
    next_sum = sum - {4'h0, window[ptr]} + {4'h0, link.sample}; // [R11]
  end

  // window store; flush clears it so stale samples never leak in
  always_ff @(posedge aclk) begin
    if (!aresetn || link.flush) begin
      for (int k = 0; k < `WINDOW_LEN; k++) begin
        window[k] <= 8'h00;
      end
      ptr <= 4'h0;
      sum <= 12'h000;
    end else if (link.sample_valid) begin
      window[ptr] <= link.sample;
      ptr <= ptr + 4'h1;
      sum <= next_sum;
    end
  end

  // one average per sample, so the output rate equals the sample rate
  always_ff @(posedge aclk) begin
    if (!aresetn || link.flush) begin
      link.avg_valid <= 1'b0;
      link.avg <= 8'h00;
    end else begin
      link.avg_valid <= link.sample_valid; // [R12]
      if (link.sample_valid) begin
        link.avg <= next_sum[11:`WINDOW_SHIFT]; // [R11]
      end
    end
  end
endmodule

/* rtl/rx_signal_strength_irq.sv */
// receiver control and signal-strength measurement with interrupt
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "strength_cfg.svh"
module rx_signal_strength_irq (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire strength_pkg::addr_type awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire strength_pkg::word_type wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire strength_pkg::addr_type araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output strength_pkg::word_type rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // levels of the I and Q amplifier chains, half-dB units
  input wire strength_pkg::level_type i_level,
  input wire strength_pkg::level_type q_level,
  // analog front-end controls
  output logic rx_enable,
  output logic [1:0] intermediate_gain_sel,
  output logic [3:0] passive_filter_bw,
  output logic [3:0] active_filter_cutoff,
  output logic complex_filter_enable,
  output logic [3:0] complex_filter_centre,
  // interrupts
  output logic strength_irq,
  output logic interrupt_pin_a,
  output logic interrupt_pin_b
);
  import strength_pkg::*;

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // accumulator step for one deviation unit at sixteen samples a period
  localparam logic [63:0] STEP_WIDE =
    ((64'd1 << 32) * `SAMPLES_PER_PERIOD * `DEV_UNIT_HZ) / `CLK_HZ;
  localparam logic [31:0] STEP_UNIT = STEP_WIDE[31:0];

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // address decode, shared by the write and read paths
  function automatic reg_sel_type decode(input addr_type a);
    reg_sel_type s;
    s = SEL_NONE;
    if (a == `OFS_CONTROL) begin
      s = SEL_CONTROL;
    end else if (a == `OFS_FILTER) begin
      s = SEL_FILTER;
    end else if (a == `OFS_DEVIATION) begin
      s = SEL_DEVIATION;
    end else if (a == `OFS_THRESHOLD) begin
      s = SEL_THRESHOLD;
    end else if (a == `OFS_STRENGTH) begin
      s = SEL_STRENGTH;
    end else if (a == `OFS_IRQ_STATUS) begin
      s = SEL_IRQ_STATUS;
    end else if (a == `OFS_IRQ_MASK) begin
      s = SEL_IRQ_MASK;
    end else if (a == `OFS_IRQ_ROUTE) begin
      s = SEL_IRQ_ROUTE;
    end
    return s;
  endfunction

  // merge written bytes into an old word by strobe
  function automatic word_type merge(input word_type old, input word_type nw,
                                     input logic [3:0] strb);
    word_type m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0] operating_mode_sel;      // chip mode
  logic [7:0] deviation_setting;       // deviation minus one, 25 kHz units
  level_type strength_threshold;       // interrupt threshold
  level_type strength_value;           // published strength
  logic strength_irq_status;           // sticky, write one to clear
  logic strength_irq_mask;             // one passes the event
  logic irq_route_pin0;                // steer to pin a
  logic irq_route_pin1;                // steer to pin b

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  wr_state_type wr_state;
  addr_type aw_addr;                   // latched write address
  logic aw_held;                       // address taken, waiting for data
  word_type w_data;                    // latched write data
  logic [3:0] w_strb;
  logic w_held;                        // data taken, waiting for address
  logic wr_fire;                       // one-cycle register update
  reg_sel_type wr_sel;
  word_type wr_word;                   // merged value for the target

  // address and data are taken independently, in either order
  assign awready = !aw_held && (wr_state == WR_IDLE);
  assign wready = !w_held && (wr_state == WR_IDLE);
  assign wr_fire = aw_held && w_held && (wr_state == WR_IDLE);
  assign wr_sel = decode(aw_addr);

  // latch the address beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // latch the data beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // response: two cycles after both beats, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state <= WR_RESP;
            bvalid <= 1'b1;
            // unmapped offsets answer slave error and change nothing
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_IDLE;
            bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    wr_word = merge(32'h00000000, w_data, w_strb);
    case (wr_sel)
      SEL_CONTROL: begin
        wr_word = merge({25'h0, complex_filter_enable, intermediate_gain_sel,
                         1'b0, operating_mode_sel}, w_data, w_strb);
      end
      SEL_FILTER: begin
        wr_word = merge({20'h0, complex_filter_centre, active_filter_cutoff,
                         passive_filter_bw}, w_data, w_strb);
      end
      default: begin
        wr_word = merge(32'h00000000, w_data, w_strb);
      end
    endcase
  end

  // mode, gain and filter enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operating_mode_sel <= `MODE_RESET;
      intermediate_gain_sel <= `GAIN_RESET; // [R03]
      complex_filter_enable <= 1'b0;
    end else if (wr_fire && wr_sel == SEL_CONTROL) begin
      operating_mode_sel <= wr_word[`MODE_LSB +: 3];
      intermediate_gain_sel <= wr_word[`GAIN_LSB +: 2]; // [R02]
      complex_filter_enable <= wr_word[`CPLX_EN_BIT]; // [R05]
    end
  end

  // receive enable follows the mode code directly
  assign rx_enable = (operating_mode_sel == `MODE_RECEIVE); // [R01]

  // channel filter settings go straight to the analog filters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      passive_filter_bw <= 4'(`FILTER_RESET >> `PASSIVE_LSB);
      active_filter_cutoff <= 4'(`FILTER_RESET >> `CUTOFF_LSB);
      complex_filter_centre <= 4'(`FILTER_RESET >> `CENTRE_LSB);
    end else if (wr_fire && wr_sel == SEL_FILTER) begin
      passive_filter_bw <= wr_word[`PASSIVE_LSB +: 4]; // [R04]
      active_filter_cutoff <= wr_word[`CUTOFF_LSB +: 4]; // [R06]
      complex_filter_centre <= wr_word[`CENTRE_LSB +: 4]; // [R07]
    end
  end

  // deviation, threshold, mask and routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deviation_setting <= `DEVIATION_RESET;
      strength_threshold <= `THRESHOLD_RESET;
      strength_irq_mask <= 1'b0;
      irq_route_pin0 <= 1'b0;
      irq_route_pin1 <= 1'b0;
    end else if (wr_fire) begin
      if (wr_sel == SEL_DEVIATION) begin
        deviation_setting <= wr_word[7:0];
      end else if (wr_sel == SEL_THRESHOLD) begin
        strength_threshold <= wr_word[7:0];
      end else if (wr_sel == SEL_IRQ_MASK) begin
        strength_irq_mask <= wr_word[`STRENGTH_IRQ_BIT];
      end else if (wr_sel == SEL_IRQ_ROUTE) begin
        irq_route_pin0 <= wr_word[`ROUTE_PIN0_BIT]; // [R17]
        irq_route_pin1 <= wr_word[`ROUTE_PIN1_BIT]; // [R17]
      end
    end
  end

  // ----------------------------------------------------------------
  // sampling clock from the deviation setting
  // ----------------------------------------------------------------
  // one accumulator serves both keying modes: in on-off keying the
  // deviation is expected to equal the second IF, so the same rate works
  logic [31:0] phase_acc;              // fractional sample phase
  logic [40:0] step_prod;              // step for this deviation
  logic [32:0] phase_sum;              // carry marks a sample instant
  strength_if link ();

  assign step_prod = {1'b0, STEP_UNIT} * ({1'b0, deviation_setting} + 9'h001);
  assign phase_sum = {1'b0, phase_acc} + {1'b0, step_prod[31:0]};

  // phase accumulator runs only while receiving
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_enable) begin
      phase_acc <= 32'h00000000;
    end else begin
      phase_acc <= phase_sum[31:0]; // [R09] [R10]
    end
  end

  // ----------------------------------------------------------------
  // sample capture: mean of the I and Q levels
  // ----------------------------------------------------------------
  logic [8:0] iq_sum;
  assign iq_sum = {1'b0, i_level} + {1'b0, q_level};

  // sixteen captures per deviation period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.sample_valid <= 1'b0;
      link.sample <= 8'h00;
    end else begin
      link.sample_valid <= rx_enable && phase_sum[32]; // [R09] [R10]
      if (phase_sum[32]) begin
        link.sample <= iq_sum[8:1];
      end
    end
  end

  // leaving receive empties the window so a restart begins clean
  assign link.flush = !rx_enable;

  strength_avg averager (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link)
  );

  // ----------------------------------------------------------------
  // published strength with gain compensation
  // ----------------------------------------------------------------
  // each gain step removes 4.5 dB, i.e. nine half-dB counts; adding them
  // back keeps the reading referred to the input, saturating at full scale
  logic [9:0] comp_sum;
  level_type next_strength;

  assign comp_sum = {2'h0, link.avg} +
                    {2'h0, `GAIN_STEP_HALF_DB} * {8'h00, intermediate_gain_sel};
  assign next_strength = (comp_sum > 10'h0FF) ? 8'hFF : comp_sum[7:0]; // [R13]

  // refreshed on every new average
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strength_value <= 8'h00;
    end else if (link.avg_valid) begin
      strength_value <= next_strength; // [R12] [R02]
    end
  end

  // ----------------------------------------------------------------
  // threshold interrupt
  // ----------------------------------------------------------------
  logic strength_event;                // update above threshold
  logic status_clear;                  // software writes one

  assign strength_event = link.avg_valid &&
                          (next_strength > strength_threshold); // [R15] [R19]
  assign status_clear = wr_fire && (wr_sel == SEL_IRQ_STATUS) &&
                        wr_word[`STRENGTH_IRQ_BIT];

  // a new event in the clearing cycle wins so no crossing is lost;
  // values below the threshold never clear the bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strength_irq_status <= 1'b0;
    end else if (strength_event) begin
      strength_irq_status <= 1'b1; // [R15] [R19]
    end else if (status_clear) begin
      strength_irq_status <= 1'b0; // [R16]
    end
  end

  // level interrupt while the unmasked status is set
  assign strength_irq = strength_irq_status && strength_irq_mask;

  // steer the interrupt onto either pin
  logic [1:0] route_bits;
  logic [1:0] pin_out;
  assign route_bits = {irq_route_pin1, irq_route_pin0};

  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign pin_out[p] = strength_irq && route_bits[p]; // [R17]
  end

  assign interrupt_pin_a = pin_out[0];
  assign interrupt_pin_b = pin_out[1];

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  rd_state_type rd_state;
  reg_sel_type rd_sel;
  word_type rd_word;

  assign arready = (rd_state == RD_IDLE);
  assign rd_sel = decode(araddr);

  // read mux; reserved bits read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (rd_sel)
      SEL_CONTROL: begin
        rd_word = {25'h0, complex_filter_enable, intermediate_gain_sel,
                   1'b0, operating_mode_sel};
      end
      SEL_FILTER: begin
        rd_word = {20'h0, complex_filter_centre, active_filter_cutoff,
                   passive_filter_bw};
      end
      SEL_DEVIATION: begin
        rd_word = {24'h0, deviation_setting};
      end
      SEL_THRESHOLD: begin
        rd_word = {24'h0, strength_threshold};
      end
      SEL_STRENGTH: begin
        rd_word = {24'h0, strength_value};
      end
      SEL_IRQ_STATUS: begin
        rd_word = {31'h0, strength_irq_status};
      end
      SEL_IRQ_MASK: begin
        rd_word = {31'h0, strength_irq_mask};
      end
      SEL_IRQ_ROUTE: begin
        rd_word = {30'h0, irq_route_pin1, irq_route_pin0};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // data one cycle after the address, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (arvalid) begin
            rd_state <= RD_DATA;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        RD_DATA: begin
          if (rready) begin
            rd_state <= RD_IDLE;
            rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end
endmodule

/* dv/level_source.sv */
// far-side model: I and Q amplifier chain levels
`timescale 1ns/1ps
module level_source (
  input wire logic aclk,
  input wire strength_pkg::level_type src_level,
  output strength_pkg::level_type i_level,
  output strength_pkg::level_type q_level
);
  import strength_pkg::*;
  // chains sit four half-dB steps apart so the I/Q mean is really formed
  always_ff @(posedge aclk) begin
    i_level <= src_level + 8'h02;
    q_level <= src_level - 8'h02;
  end
endmodule

/* dv/strength_sva.sv */
// concurrent checks on the strength block ports
`timescale 1ns/1ps
module strength_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rx_enable,
  input wire logic [1:0] intermediate_gain_sel,
  input wire logic strength_irq,
  input wire logic interrupt_pin_a,
  input wire logic interrupt_pin_b
);
  // receive enable and gain only move, and the interrupt only falls, on a completed write
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence s_wr_answer; bvalid && !awready && !wready; endsequence
  // beats are latched on one edge and answered on the next, so two ticks
  property p_wr_resp; s_wr_taken |-> ##2 s_wr_answer; endproperty
  property p_rd_lat; arvalid && arready |=> rvalid && !arready; endproperty
  property p_reset; $rose(aresetn) |-> !rx_enable && intermediate_gain_sel == 2'h0; endproperty
  property p_rx; $changed(rx_enable) |-> $rose(bvalid); endproperty
  property p_gain; $changed(intermediate_gain_sel) |-> $rose(bvalid); endproperty
  property p_sticky; $fell(strength_irq) |-> $rose(bvalid); endproperty
  property p_pins; interrupt_pin_a || interrupt_pin_b |-> strength_irq; endproperty
  property p_rd_block; rvalid |-> !arready; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer missing");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
  a_reset: assert property (p_reset) else $error("reset values wrong");
  a_rx: assert property (p_rx) else $error("receive enable moved alone");
  a_gain: assert property (p_gain) else $error("gain moved alone");
  a_sticky: assert property (p_sticky) else $error("status dropped alone");
  a_pins: assert property (p_pins) else $error("pin without interrupt");
  a_rd_block: assert property (p_rd_block) else $error("read taken while busy");
endmodule
bind rx_signal_strength_irq strength_sva i_sva (.*);

/* dv/rx_signal_strength_irq_tb_top.sv */
// self-checking bench for the strength block
`timescale 1ns/1ps
`include "strength_cfg.svh"
module rx_signal_strength_irq_tb_top;
  import strength_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_enable, complex_filter_enable;
  logic strength_irq, interrupt_pin_a, interrupt_pin_b;
  logic [1:0] bresp, rresp, intermediate_gain_sel;
  logic [3:0] passive_filter_bw, active_filter_cutoff, complex_filter_centre;
  logic [3:0] wstrb = 4'hF; // full words only
  addr_type awaddr = 8'h00, araddr = 8'h00;
  word_type wdata = 32'h0, rdata;
  level_type i_level, q_level, src_level = 8'h28; // mean level of both chains
  int n_fail = 0, checks_done = 0;
  always #4 aclk = ~aclk; // 125 MHz
  rx_signal_strength_irq i_dut (.*);
  level_source i_src (.*);
  // compare one result, x never matches
  task automatic chk(input word_type got, input word_type exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one bus access: write d, or read and expect d; readies sampled mid-cycle
  task automatic xfer(input logic wr, input addr_type a, input word_type d, input logic [1:0] er);
    logic ah, wh, done;
    logic [1:0] r;
    word_type got;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    arvalid <= !wr;
    bready <= wr;
    rready <= !wr;
    done = 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ah = (awvalid & awready) | (arvalid & arready);
      wh = wvalid & wready;
      done = wr ? bvalid : rvalid;
      r = wr ? bresp : rresp;
      got = rdata;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (ah) arvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
    if (!done) begin
      $display("[FAIL] %0t bus wait ran out", $time);
      n_fail++;
      conclude();
    end
    chk(r, er, "resp");
    if (!wr) chk(got, d, "rdata");
  endtask
  // reset values, unmapped and read-only places
  task automatic t_reset;
    chk({rx_enable, intermediate_gain_sel}, 3'h0, "reset pins");
    xfer(1'b0, `OFS_CONTROL, {29'h0, `MODE_RESET}, 2'h0);
    xfer(1'b0, `OFS_DEVIATION, 32'(`DEVIATION_RESET), 2'h0);
    xfer(1'b1, 8'h20, 32'h1, 2'h2);
    xfer(1'b0, 8'h20, 32'h0, 2'h2);
    xfer(1'b1, `OFS_STRENGTH, 32'hFF, 2'h0);
    xfer(1'b0, `OFS_STRENGTH, 32'h0, 2'h0);
  endtask
  // every gain step, a non-receive mode and the filter fields
  task automatic t_controls;
    for (int g = 0; g < 4; g++) begin
      xfer(1'b1, `OFS_CONTROL, 32'(`MODE_RECEIVE) | (g << `GAIN_LSB), 2'h0);
      chk({rx_enable, intermediate_gain_sel}, {1'b1, g[1:0]}, "gain");
    end
    xfer(1'b1, `OFS_CONTROL, 32'h42, 2'h0);
    chk({rx_enable, complex_filter_enable}, 2'h1, "mode 2");
    xfer(1'b1, `OFS_FILTER, 32'hA5C, 2'h0);
    chk({passive_filter_bw, active_filter_cutoff, complex_filter_centre}, 12'hC5A, "f");
  endtask
  // window fill, threshold edge, gain offset, routing, mask and clear
  task automatic t_strength;
    xfer(1'b1, `OFS_DEVIATION, 32'h3, 2'h0);
    xfer(1'b1, `OFS_THRESHOLD, 32'h28, 2'h0);
    xfer(1'b1, `OFS_IRQ_MASK, 32'h1, 2'h0);
    xfer(1'b1, `OFS_IRQ_ROUTE, 32'h1, 2'h0);
    xfer(1'b1, `OFS_CONTROL, 32'h3, 2'h0);
    // sixteen samples at about 78 cycles each fill the window
    repeat (1500) @(posedge aclk);
    xfer(1'b0, `OFS_STRENGTH, 32'h28, 2'h0);
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0, 2'h0);
    xfer(1'b1, `OFS_CONTROL, 32'h13, 2'h0);
    repeat (200) @(posedge aclk);
    xfer(1'b0, `OFS_STRENGTH, 32'h31, 2'h0);
    chk({strength_irq, interrupt_pin_a, interrupt_pin_b}, 3'h6, "pin a");
    xfer(1'b1, `OFS_IRQ_ROUTE, 32'h2, 2'h0);
    chk({interrupt_pin_a, interrupt_pin_b}, 2'h1, "pin b");
    xfer(1'b1, `OFS_CONTROL, 32'h3, 2'h0);
    repeat (200) @(posedge aclk);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h0, 2'h0);
    chk(strength_irq, 1'b1, "sticky");
    xfer(1'b1, `OFS_IRQ_MASK, 32'h0, 2'h0);
    chk({strength_irq, interrupt_pin_b}, 2'h0, "masked");
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h1, 2'h0);
    xfer(1'b1, `OFS_IRQ_STATUS, 32'h1, 2'h0);
    xfer(1'b0, `OFS_IRQ_STATUS, 32'h0, 2'h0);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_controls();
    t_strength();
    conclude();
  end
endmodule
